// ### wake_defs.svh
// Offsets, field positions, reset values and constants of the wake source block
`ifndef WAKE_DEFS_SVH
`define WAKE_DEFS_SVH
`define ADDR_W        12
`define SRC_OFF       12'h144
`define CTRL_OFF      12'h148
`define CFG_BASE      12'h150
`define CFG_LAST      12'h1cc
`define NUM_FILT      32
`define MASK_BYTES    128
`define PIN_MSB       31
`define PIN_LSB       20
`define V6_BIT        16
`define V4_BIT        15
`define TXI_BIT       14
`define RXI_BIT       13
`define RFE_BIT       12
`define OWN_BIT       11
`define MAGIC_BIT     10
`define BCAST_BIT     9
`define PAT_BIT       8
`define IDX_MSB       4
`define SRC_RW_MASK   32'hfff1_ff1f
`define SRC_RESET     32'h0000_0000
`define CFG_EN_BIT    31
`define CFG_ALL_BIT   24
`define CFG_MC_BIT    25
`define CFG_OFF_MSB   23
`define CFG_OFF_LSB   16
`define CFG_CRC_MSB   15
`define CFG_MASK      32'h83ff_ffff
`define CFG_RESET     32'h0000_0000
`define CTL_TXW_BIT   0
`define CTL_RXW_BIT   1
`define CTL_LPE_BIT   2
`define CTL_RESET     3'h0
`define CRC_POLY      16'h8005
`define CRC_INIT      16'hffff
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// ### wake_pkg.sv
// Types shared by the wake source block and its submodules
package wake_pkg;
`include "wake_defs.svh"

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} rd_state_t;

  typedef struct packed {
    logic [31:0]        status;
    logic [2:0]         ctrl;
    logic               aw_held;
    logic [11:0]        awaddr;
    logic               w_held;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    rd_state_t          rd;
    logic [11:0]        araddr;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               wake_req;
  } wake_state_t;

  typedef struct packed {
    logic [31:0][31:0]  word;
    logic [31:0]        rdata;
  } cfg_state_t;

  typedef struct packed {
    logic [8:0]         pos;
    logic               mcast;
    logic [31:0][15:0]  crc;
    logic               match_valid;
    logic [4:0]         match_index;
  } crc_state_t;
endpackage

// ### pattern_cfg_store.sv
// Storage of the 32 pattern filter configuration words
`timescale 1ns/10ps
`include "wake_defs.svh"
module pattern_cfg_store (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           reset_n,
  // Bus write port
  input  wire logic           we,
  input  wire logic [4:0]     widx,
  input  wire logic [31:0]    wdata,
  input  wire logic [3:0]     wstrb,
  // Filter 0 image restore
  input  wire logic           restore,
  input  wire logic [31:0]    image,
  // Bus read port, registered
  input  wire logic [4:0]     ridx,
  output logic      [31:0]    rdata,
  // All filters in parallel
  output logic      [1023:0]  cfg_flat
);
  wake_pkg::cfg_state_t q;
  wake_pkg::cfg_state_t n;

  always_comb begin
    n = q;
    if (we) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb[b]) begin
          n.word[widx][b*8 +: 8] = wdata[b*8 +: 8] & 8'(`CFG_MASK >> (b*8));
        end
      end
    end
    // Image wins over a bus write in the same cycle
    if (restore) begin
      n.word[0] = image & `CFG_MASK;
    end
    n.rdata = q.word[ridx];
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rdata    = q.rdata;
  assign cfg_flat = q.word;
endmodule

// ### pattern_crc_bank.sv
// Parallel CRC-16 engines, one per pattern filter
`timescale 1ns/10ps
`include "wake_defs.svh"
module pattern_crc_bank (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           reset_n,
  // Received frame bytes
  input  wire logic           rx_valid,
  input  wire logic [7:0]     rx_data,
  input  wire logic           rx_last,
  input  wire logic           rx_good,
  // Filter settings
  input  wire logic [1023:0]  cfg_flat,
  input  wire logic [4095:0]  byte_masks,
  // Match result
  output logic                match_valid,
  output logic      [4:0]     match_index
);
  wake_pkg::crc_state_t q;
  wake_pkg::crc_state_t n;

  // MSB-first CRC-16, polynomial 0x8005, preset all ones
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int k = 7; k >= 0; k--) begin
      r = (r[15] ^ d[k]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  always_comb begin
    logic [31:0]  cfg;
    logic [8:0]   rel;
    logic [15:0]  c;
    logic         cls_ok;
    logic         mc;
    logic         found;
    cfg = '0;
    rel = '0;
    c = '0;
    cls_ok = 1'b0;
    found = 1'b0;
    mc = 1'b0;
    n = q;
    n.match_valid = 1'b0;
    mc = (q.pos == 9'h0) ? rx_data[0] : q.mcast;
    if (rx_valid) begin
      n.mcast = mc;
      n.pos = (q.pos == 9'h1ff) ? q.pos : q.pos + 9'h1;
      for (int i = 0; i < `NUM_FILT; i++) begin
        cfg = cfg_flat[i*32 +: 32];
        rel = q.pos - {1'b0, cfg[`CFG_OFF_MSB:`CFG_OFF_LSB]};
        c = (q.pos == 9'h0) ? `CRC_INIT : q.crc[i];
        if (q.pos >= {1'b0, cfg[`CFG_OFF_MSB:`CFG_OFF_LSB]} && rel < 9'(`MASK_BYTES)
            && byte_masks[i*`MASK_BYTES + int'(rel[6:0])]) begin
          c = crc16_byte(c, rx_data);
        end
        n.crc[i] = c;
        // Class bit 24 set means all frames; else bit 25 picks multicast
        cls_ok = cfg[`CFG_ALL_BIT] || (cfg[`CFG_MC_BIT] == mc);
        if (rx_last && rx_good && !found && cfg[`CFG_EN_BIT] && cls_ok
            && c == cfg[`CFG_CRC_MSB:0]) begin
          found = 1'b1;
          n.match_index = 5'(i);
        end
      end
      n.match_valid = found;
      if (rx_last) begin
        n.pos = 9'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign match_valid = q.match_valid;
  assign match_index = q.match_index;
endmodule

// ### wake_source_and_pattern_filters.sv
// Wake source status register, pattern filters and AXI4-Lite slave
// Function
// - Ignore wake events while the device is entering suspend.
// - Ignore wake events once wake-up has begun.
// - Set every matching source bit when one packet meets several conditions.
// - Source bits stay set until software writes one to clear them; bits 14 and 13 also clear while low power Ethernet is disabled.
// - Bits 31:20 flag which general purpose pin caused wake.
// - Bit 16 for IPv6 TCP SYN wake, bit 15 for IPv4.
// - Bit 14 on transmit idle exit after request delay expiry.
// - Transmit idle wake bit never sets without its enable.
// - Both idle wake bits held low while low power Ethernet disabled.
// - Bit 13 on receive idle exit, only with receive wake enable.
// - Bit 12 on a clean frame passing the receive filter engine.
// - Bit 11 on a frame addressed to our own address.
// - Bit 10 on magic packet, bit 9 on broadcast frame.
// - Bit 8 on pattern match, index of filter in bits 4:0.
// - Thirty-two pattern filters, each covering up to 128 frame bytes.
// - A filter matches only while its bit 31 enable is set.
// - Class 00 unicast only, 10 multicast only, low bit set all.
// - Offset field gives first CRC byte, zero at destination address.
// - CRC-16 over masked bytes compared with stored value signals match.
// - Filter 0 takes its boot image, restored on USB or lite reset.
// - Byte mask bit j includes frame byte offset plus j.
`timescale 1ns/10ps
`include "wake_defs.svh"
module wake_source_and_pattern_filters (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           reset_n,
  // AXI4-Lite write address and data
  input  wire logic           awvalid,
  output logic                awready,
  input  wire logic [11:0]    awaddr,
  input  wire logic           wvalid,
  output logic                wready,
  input  wire logic [31:0]    wdata,
  input  wire logic [3:0]     wstrb,
  // AXI4-Lite write response
  output logic                bvalid,
  input  wire logic           bready,
  output logic      [1:0]     bresp,
  // AXI4-Lite read
  input  wire logic           arvalid,
  output logic                arready,
  input  wire logic [11:0]    araddr,
  output logic                rvalid,
  input  wire logic           rready,
  output logic      [31:0]    rdata,
  output logic      [1:0]     rresp,
  // Power state
  input  wire logic           suspend_state,
  input  wire logic           entering_suspend,
  input  wire logic           wake_started,
  // Wake events, one-cycle pulses
  input  wire logic [11:0]    pin_wake_events,
  input  wire logic           v6_syn_event,
  input  wire logic           v4_syn_event,
  input  wire logic           tx_idle_exit_event,
  input  wire logic           rx_idle_exit_event,
  input  wire logic           filter_engine_event,
  input  wire logic           own_address_event,
  input  wire logic           magic_event,
  input  wire logic           broadcast_event,
  // Received frame bytes for pattern matching
  input  wire logic           rx_valid,
  input  wire logic [7:0]     rx_data,
  input  wire logic           rx_last,
  input  wire logic           rx_good,
  input  wire logic [4095:0]  pattern_byte_mask,
  // Filter 0 image and resets
  input  wire logic           image_load,
  input  wire logic [31:0]    image_cfg0,
  input  wire logic           usb_reset,
  input  wire logic           lite_reset,
  // Wake recorded
  output logic                wake_request
);
  wake_pkg::wake_state_t q;
  wake_pkg::wake_state_t n;

  logic                mem_we;
  logic [4:0]          mem_widx;
  logic [4:0]          mem_ridx;
  logic [31:0]         mem_rdata;
  logic [1023:0]       cfg_flat;
  logic                match_valid;
  logic [4:0]          match_index;

  function automatic logic cfg_hit(input logic [11:0] a);
    return a >= `CFG_BASE && a <= `CFG_LAST && a[1:0] == 2'h0;
  endfunction

  function automatic logic [4:0] cfg_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - `CFG_BASE;
    return d[6:2];
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register decode codes
  localparam logic [1:0] SEL_SRC  = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_CFG  = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  // One decode shared by the write and read paths
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    logic [1:0] s;
    s = SEL_NONE;
    if (a == `SRC_OFF) begin
      s = SEL_SRC;
    end else if (a == `CTRL_OFF) begin
      s = SEL_CTRL;
    end else if (cfg_hit(a)) begin
      s = SEL_CFG;
    end
    return s;
  endfunction

  // Raw events placed at their status bit positions
  function automatic logic [31:0] event_vector(
    input logic [11:0] pins,
    input logic        v6,
    input logic        v4,
    input logic        txi,
    input logic        rxi,
    input logic        receive_filter_engine,
    input logic        own,
    input logic        magic,
    input logic        bcast,
    input logic        pat
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`PIN_MSB:`PIN_LSB] = pins;
    v[`V6_BIT] = v6;
    v[`V4_BIT] = v4;
    v[`TXI_BIT] = txi;
    v[`RXI_BIT] = rxi;
    v[`RFE_BIT] = receive_filter_engine;
    v[`OWN_BIT] = own;
    v[`MAGIC_BIT] = magic;
    v[`BCAST_BIT] = bcast;
    v[`PAT_BIT] = pat;
    return v;
  endfunction

  // Set beats a same-cycle clear; idle bits follow the enable
  function automatic logic [31:0] status_next(
    input logic [31:0] old,
    input logic [31:0] clr,
    input logic [31:0] set,
    input logic [4:0]  idx,
    input logic        lpe
  );
    logic [31:0] s;
    s = ((old & ~clr) | set) & `SRC_RW_MASK;
    if (set[`PAT_BIT]) begin
      s[`IDX_MSB:0] = idx;
    end
    if (!lpe) begin
      s[`TXI_BIT] = 1'b0;
      s[`RXI_BIT] = 1'b0;
    end
    return s;
  endfunction

  pattern_cfg_store u_cfg (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .we       (mem_we),
    .widx     (mem_widx),
    .wdata    (q.wdata),
    .wstrb    (q.wstrb),
    .restore  (image_load | usb_reset | lite_reset),
    .image    (image_cfg0),
    .ridx     (mem_ridx),
    .rdata    (mem_rdata),
    .cfg_flat (cfg_flat)
  );

  pattern_crc_bank u_crc (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .rx_valid    (rx_valid),
    .rx_data     (rx_data),
    .rx_last     (rx_last),
    .rx_good     (rx_good),
    .cfg_flat    (cfg_flat),
    .byte_masks  (pattern_byte_mask),
    .match_valid (match_valid),
    .match_index (match_index)
  );

  always_comb begin
    logic         armed;
    logic         lpe;
    logic [31:0]  set;
    logic [31:0]  clr;
    logic [31:0]  tmp;
    armed = 1'b0;
    lpe = 1'b0;
    set = '0;
    clr = '0;
    tmp = '0;
    n = q;
    mem_we = 1'b0;
    mem_widx = cfg_idx(q.awaddr);
    mem_ridx = cfg_idx(araddr);
    n.wake_req = 1'b0;

    // Events count only in a settled suspend, before wake-up starts
    armed = suspend_state && !entering_suspend && !wake_started;
    lpe = q.ctrl[`CTL_LPE_BIT];
    set = event_vector(pin_wake_events,
                       v6_syn_event,
                       v4_syn_event,
                       tx_idle_exit_event && q.ctrl[`CTL_TXW_BIT] && lpe,
                       rx_idle_exit_event && q.ctrl[`CTL_RXW_BIT] && lpe,
                       filter_engine_event,
                       own_address_event,
                       magic_event,
                       broadcast_event,
                       match_valid);
    if (!armed) begin
      set = '0;
    end

    // Write address and data may arrive in either order
    if (awvalid && q.awready) begin
      n.aw_held = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.w_held = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (reg_sel(q.awaddr))
        SEL_SRC: begin
          clr = strb_merge(32'h0, q.wdata, q.wstrb) & `SRC_RW_MASK;
        end
        SEL_CTRL: begin
          tmp = strb_merge({29'h0, q.ctrl}, q.wdata, q.wstrb);
          n.ctrl = tmp[2:0];
        end
        SEL_CFG: begin
          mem_we = 1'b1;
        end
        default: begin
          n.bresp = `RESP_SLVERR;
        end
      endcase
    end else if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    n.awready = !n.aw_held;
    n.wready = !n.w_held;

    // A new event beats a software clear in the same cycle
    n.status = status_next(q.status, clr, set, match_index, lpe);
    n.wake_req = |set;

    // Read: one wait cycle lets the filter store register its data
    case (q.rd)
      wake_pkg::RD_IDLE: begin
        if (arvalid && q.arready) begin
          n.araddr = araddr;
          n.arready = 1'b0;
          n.rd = wake_pkg::RD_WAIT;
        end
      end
      wake_pkg::RD_WAIT: begin
        n.rresp = `RESP_OKAY;
        case (reg_sel(q.araddr))
          SEL_SRC: begin
            n.rdata = q.status;
          end
          SEL_CTRL: begin
            n.rdata = {29'h0, q.ctrl};
          end
          SEL_CFG: begin
            n.rdata = mem_rdata;
          end
          default: begin
            n.rdata = 32'h0;
            n.rresp = `RESP_SLVERR;
          end
        endcase
        n.rvalid = 1'b1;
        n.rd = wake_pkg::RD_RESP;
      end
      wake_pkg::RD_RESP: begin
        if (rready) begin
          n.rvalid = 1'b0;
          n.arready = 1'b1;
          n.rd = wake_pkg::RD_IDLE;
        end
      end
      default: begin
        n.rd = wake_pkg::RD_IDLE;
        n.rvalid = 1'b0;
        n.arready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.status <= `SRC_RESET;
      q.ctrl <= `CTL_RESET;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.rd <= wake_pkg::RD_IDLE;
    end else begin
      q <= n;
    end
  end

  assign awready      = q.awready;
  assign wready       = q.wready;
  assign bvalid       = q.bvalid;
  assign bresp        = q.bresp;
  assign arready      = q.arready;
  assign rvalid       = q.rvalid;
  assign rdata        = q.rdata;
  assign rresp        = q.rresp;
  assign wake_request = q.wake_req;
endmodule

// ### wake_source_checker.sv
// Port-level assertions for the wake source block
`timescale 1ns/10ps
module wake_source_checker (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // Power state and events
  input wire logic        suspend_state,
  input wire logic        entering_suspend,
  input wire logic        wake_started,
  input wire logic [11:0] pin_wake_events,
  input wire logic        v6_syn_event,
  input wire logic        v4_syn_event,
  input wire logic        tx_idle_exit_event,
  input wire logic        rx_idle_exit_event,
  input wire logic        filter_engine_event,
  input wire logic        own_address_event,
  input wire logic        magic_event,
  input wire logic        broadcast_event,
  input wire logic        rx_valid,
  input wire logic        rx_last,
  input wire logic        wake_request
);
  logic armed;
  logic any_ev;
  logic frm_ev;
  assign armed = suspend_state & ~entering_suspend & ~wake_started;
  assign frm_ev = filter_engine_event | own_address_event | magic_event | broadcast_event;
  assign any_ev = armed & (|{pin_wake_events, v6_syn_event, v4_syn_event, tx_idle_exit_event,
                             rx_idle_exit_event, frm_ev});
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence ar_take;
    arvalid && arready;
  endsequence
  sequence w_take;
    awvalid && awready && wvalid && wready && !bvalid;
  endsequence
  a_read_latency: assert property (ar_take |=> !rvalid ##1 rvalid)
    else $error("read answer not two edges after address");
  a_write_latency: assert property (w_take |=> !bvalid ##1 bvalid)
    else $error("write answer not two edges after address");
  a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_entry_ignored: assert property (entering_suspend [*3] |=> !wake_request)
    else $error("wake recorded while entering suspend");
  a_started_ignored: assert property (wake_started [*3] |=> !wake_request)
    else $error("wake recorded after wake-up began");
  a_pin_wakes: assert property (armed && |pin_wake_events |=> wake_request)
    else $error("pin event did not wake");
  a_syn_wakes: assert property (armed && (v6_syn_event || v4_syn_event) |=> wake_request)
    else $error("syn event did not wake");
  a_frame_wakes: assert property (armed && frm_ev |=> wake_request)
    else $error("frame event did not wake");
  a_wake_has_cause: assert property (wake_request |->
      $past(any_ev) || $past(rx_valid && rx_last) || $past(rx_valid && rx_last, 2))
    else $error("wake request without cause");
endmodule
bind wake_source_and_pattern_filters wake_source_checker chk_i (.ref_clk, .reset_n, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .suspend_state,
  .entering_suspend, .wake_started, .pin_wake_events, .v6_syn_event, .v4_syn_event, .tx_idle_exit_event,
  .rx_idle_exit_event, .filter_engine_event, .own_address_event, .magic_event, .broadcast_event,
  .rx_valid, .rx_last, .wake_request);

// ### wake_source_and_pattern_filters_test.sv
// Self-checking bench for the wake source block
`timescale 1ns/10ps
`include "wake_defs.svh"
module wake_source_and_pattern_filters_test;
  logic          ref_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready, rx_good;
  logic          arvalid, arready, rvalid, rready, rx_valid, rx_last, wake_request;
  logic [11:0]   awaddr, araddr;
  logic [31:0]   wdata, rdata, image_cfg0, rd_val;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, resp;
  logic [7:0]    rx_data;
  logic [4095:0] pattern_byte_mask;
  // Event, power and restore inputs grouped for compact pulses
  logic [19:0]   ev;
  logic [2:0]    pwr, rst3;
  int            miscompares, checks;
  wire logic [11:0] pin_wake_events;
  wire logic     v6_syn_event, v4_syn_event, tx_idle_exit_event, rx_idle_exit_event, filter_engine_event;
  wire logic     own_address_event, magic_event, broadcast_event, suspend_state, entering_suspend;
  wire logic     wake_started, image_load, usb_reset, lite_reset;
  assign {pin_wake_events, v6_syn_event, v4_syn_event, tx_idle_exit_event, rx_idle_exit_event,
          filter_engine_event, own_address_event, magic_event, broadcast_event} = ev;
  assign {suspend_state, entering_suspend, wake_started} = pwr;
  assign {image_load, usb_reset, lite_reset} = rst3;

  wake_source_and_pattern_filters DUT (.ref_clk, .reset_n, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .suspend_state, .entering_suspend, .wake_started, .pin_wake_events, .v6_syn_event, .v4_syn_event,
    .tx_idle_exit_event, .rx_idle_exit_event, .filter_engine_event, .own_address_event, .magic_event,
    .broadcast_event, .rx_valid, .rx_data, .rx_last, .rx_good, .pattern_byte_mask, .image_load,
    .image_cfg0, .usb_reset, .lite_reset, .wake_request);

  always #50 ref_clk = ~ref_clk;

  task complete_run;
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!ta || !tw) begin
      @(posedge ref_clk);
      ta = ta | awready;
      tw = tw | wready;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    do @(posedge ref_clk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
    chk(rd_val, e);
  endtask

  task pulse(input logic [19:0] v, input logic req);
    @(posedge ref_clk);
    ev <= v;
    @(posedge ref_clk);
    ev <= '0;
    #1 chk({31'h0, wake_request}, {31'h0, req});
  endtask

  task frame(input logic [47:0] f);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= f[47-8*i -: 8];
      rx_last <= (i == 5);
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // Bench's own CRC, MSB first, so a shared slip cannot hide
  function automatic logic [15:0] crc16(input logic [23:0] d);
    logic [15:0] c;
    c = `CRC_INIT;
    for (int i = 23; i >= 0; i--)
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ `CRC_POLY) : {c[14:0], 1'b0};
    return c;
  endfunction

  task t_reset;
    rdc(`SRC_OFF, `SRC_RESET);
    rdc(12'h14c, 32'h0);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    wr(12'h200, 32'hffff_ffff);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
  endtask

  task t_events;
    pulse({12'h801, 8'hcf}, 1'b1);
    repeat (20) @(posedge ref_clk);
    rdc(`SRC_OFF, 32'h8011_9e00);
    wr(`SRC_OFF, 32'h0000_0200);
    rdc(`SRC_OFF, 32'h8011_9c00);
    wr(`SRC_OFF, 32'hffff_ffff);
    rdc(`SRC_OFF, 32'h0);
  endtask

  task t_ignore;
    logic [2:0] p [3];
    p = '{3'b110, 3'b101, 3'b000};
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      pwr <= p[i];
      pulse(20'hfffff, 1'b0);
      rdc(`SRC_OFF, 32'h0);
    end
    @(posedge ref_clk);
    pwr <= 3'b100;
  endtask

  task t_idle;
    wr(`CTRL_OFF, 32'h3);
    rdc(`CTRL_OFF, 32'h3);
    pulse(20'h30, 1'b0);
    wr(`CTRL_OFF, 32'h6);
    pulse(20'h30, 1'b1);
    rdc(`SRC_OFF, 32'h2000);
    wr(`CTRL_OFF, 32'h5);
    pulse(20'h30, 1'b1);
    rdc(`SRC_OFF, 32'h6000);
    wr(`CTRL_OFF, 32'h3);
    rdc(`SRC_OFF, 32'h0);
    wr(`CTRL_OFF, 32'h0);
  endtask

  task t_cfg;
    wr(`CFG_BASE + 12'h14, 32'hffff_ffff);
    rdc(`CFG_BASE + 12'h14, `CFG_MASK);
    wstrb <= 4'h1;
    wr(`CFG_BASE + 12'h14, 32'h0);
    wstrb <= 4'hf;
    rdc(`CFG_BASE + 12'h14, `CFG_MASK & 32'hffff_ff00);
    wr(`CFG_BASE + 12'h14, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`CFG_BASE, 32'h1234_5678);
      @(posedge ref_clk);
      rst3 <= 3'b100 >> i;
      @(posedge ref_clk);
      rst3 <= 3'b000;
      rdc(`CFG_BASE, image_cfg0 & `CFG_MASK);
    end
  endtask

  task t_pattern;
    logic [15:0] c;
    c = crc16(24'h112233);
    @(posedge ref_clk);
    pattern_byte_mask <= ({4096{1'b0}} | 4096'h7) << 128 | 4096'h7 << 256 | 4096'h7 << 3968;
    wr(`CFG_BASE + 12'h04, {16'h0001, c});
    wr(`CFG_BASE + 12'h08, {16'h8201, c});
    wr(`CFG_LAST, {16'h8101, c});
    frame(48'h0211_2233_9955);
    rdc(`SRC_OFF, 32'h0000_011f);
    wr(`SRC_OFF, 32'hffff_ffff);
    frame(48'h0311_2233_4455);
    rdc(`SRC_OFF, 32'h0000_0102);
    wr(`SRC_OFF, 32'hffff_ffff);
    frame(48'h0211_2234_4455);
    rdc(`SRC_OFF, 32'h0);
  endtask

  initial begin
    ref_clk = 0;
    reset_n = 0;
    {awvalid, wvalid, bready, arvalid, rready, rx_valid, rx_last} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    rx_data = '0;
    rx_good = 1;
    pattern_byte_mask = '0;
    ev = '0;
    rst3 = '0;
    pwr = 3'b100;
    image_cfg0 = 32'hfc00_0001;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset;
    t_events;
    t_ignore;
    t_idle;
    t_cfg;
    t_pattern;
    complete_run;
  end

  // The run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    complete_run;
  end
endmodule
